/* File: verilog/chgcfg_top.sv */
`timescale 1ns/1ps
// Contract
// - termination current code, bits 7:4, default 250mA
// - end-of-charge detection gated by enable bit
// - end-of-charge deglitch time from 3-bit select
// - boost low-battery threshold code with hysteresis
// - boost low-battery protection gated by enable
// - boost overload threshold code, 111 reserved
// - adapter detection runs unless disable bit set
// - battery detection after done only if enabled
// - under-voltage stops buck when select is one
// - minimum system voltage code, default 3.6V
// - recharge offset below charge voltage target
// - fast charge time limit from 3-bit code
// - pre-charge time limit from 2-bit code
// - doubled timer during regulation when enabled
// - safety timers run only when enabled
// - hold bit freezes timer count
// - inductor overcurrent level select, low or high
module chgcfg_top #(
  parameter int US_CYCLES = chgcfg_pkg::TICK_CYCLES,
  parameter int MINUTE_TICKS = chgcfg_pkg::MINUTE_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port from the serial control interface
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  // analog and charger state inputs, asynchronous
  input wire chgcfg_pkg::chgcfg_sense_t sense_async,
  // settings to the analog loops
  output chgcfg_pkg::chgcfg_cfg_t cfg_ff,
  // control results
  output logic eoc_detected_ff,
  output logic boost_lbp_trip_ff,
  output logic buck_switch_off_ff,
  output logic adapter_detect_run_ff,
  output logic battery_detect_run_ff,
  output logic charge_stop_ff,
  output logic timer_fault_ff,
  output logic ocp_high_level_ff
);

  logic [1:0] rst_pipe_ff;
  logic rst_sync_b;
  logic [7:0] regs_ff [chgcfg_pkg::NUM_REGS];
  logic [chgcfg_pkg::SENSE_W-1:0] sync1_ff;
  logic [chgcfg_pkg::SENSE_W-1:0] sync2_ff;
  chgcfg_pkg::chgcfg_sense_t sense;
  logic [6:0] us_div_ff;
  logic us_tick;
  logic [25:0] min_div_ff;
  logic minute_tick;
  logic [13:0] deg_cnt_ff;
  logic eoc_cond;
  logic [1:0] phase_ff;
  logic timer_run;
  logic timer_restart;
  logic [10:0] timer_limit;
  logic timer_expired;
  logic wr_hit;
  logic [1:0] wr_idx;
  logic rd_hit;
  logic [1:0] rd_idx;

  // address decode shared by the write and read paths
  function automatic logic [2:0] addr_decode(input logic [7:0] addr);
    unique case (addr)
      chgcfg_pkg::TERM_OFF: addr_decode = {1'b1, chgcfg_pkg::TERM_IDX};
      chgcfg_pkg::BOOST_OFF: addr_decode = {1'b1, chgcfg_pkg::BOOST_IDX};
      chgcfg_pkg::OPTION_OFF: addr_decode = {1'b1, chgcfg_pkg::OPTION_IDX};
      chgcfg_pkg::TIMER_OFF: addr_decode = {1'b1, chgcfg_pkg::TIMER_IDX};
      default: addr_decode = 3'h0;
    endcase
  endfunction

  // deglitch time in microsecond ticks
  function automatic logic [13:0] deglitch_us(input logic [2:0] sel);
    unique case (sel)
      3'h0: deglitch_us = chgcfg_pkg::DEG_0_US;
      3'h1: deglitch_us = chgcfg_pkg::DEG_1_US;
      3'h2: deglitch_us = chgcfg_pkg::DEG_2_US;
      3'h3: deglitch_us = chgcfg_pkg::DEG_3_US;
      3'h4: deglitch_us = chgcfg_pkg::DEG_4_US;
      3'h5: deglitch_us = chgcfg_pkg::DEG_5_US;
      3'h6: deglitch_us = chgcfg_pkg::DEG_6_US;
      3'h7: deglitch_us = chgcfg_pkg::DEG_7_US;
    endcase
  endfunction

  // fast charge limit in minutes
  function automatic logic [10:0] fast_limit_min(input logic [2:0] sel);
    unique case (sel)
      3'h0: fast_limit_min = chgcfg_pkg::FC_0_MIN;
      3'h1: fast_limit_min = chgcfg_pkg::FC_1_MIN;
      3'h2: fast_limit_min = chgcfg_pkg::FC_2_MIN;
      3'h3: fast_limit_min = chgcfg_pkg::FC_3_MIN;
      3'h4: fast_limit_min = chgcfg_pkg::FC_4_MIN;
      3'h5: fast_limit_min = chgcfg_pkg::FC_5_MIN;
      3'h6: fast_limit_min = chgcfg_pkg::FC_6_MIN;
      3'h7: fast_limit_min = chgcfg_pkg::FC_7_MIN;
    endcase
  endfunction

  // pre-charge limit in minutes; the two top codes both mean the longest
  function automatic logic [10:0] pre_limit_min(input logic [1:0] sel);
    unique case (sel)
      2'h0: pre_limit_min = chgcfg_pkg::PRC_0_MIN;
      2'h1: pre_limit_min = chgcfg_pkg::PRC_1_MIN;
      2'h2, 2'h3: pre_limit_min = chgcfg_pkg::PRC_2_MIN;
    endcase
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe_ff[1];

  // two-flop synchronisers, one per sense input
  genvar gi;
  generate
    for (gi = 0; gi < chgcfg_pkg::SENSE_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= sense_async[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate
  assign sense = chgcfg_pkg::chgcfg_sense_t'(sync2_ff);

  assign {wr_hit, wr_idx} = addr_decode(reg_addr);
  assign rd_hit = wr_hit;
  assign rd_idx = wr_idx;

  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      regs_ff[chgcfg_pkg::TERM_IDX] <= chgcfg_pkg::TERM_RST;
      regs_ff[chgcfg_pkg::BOOST_IDX] <= chgcfg_pkg::BOOST_RST;
      regs_ff[chgcfg_pkg::OPTION_IDX] <= chgcfg_pkg::OPTION_RST;
      regs_ff[chgcfg_pkg::TIMER_IDX] <= chgcfg_pkg::TIMER_RST;
    end else if (reg_wr_en && wr_hit) begin
      // reserved overload code 111 is stored as written
      regs_ff[wr_idx] <= reg_wdata;
    end
  end

  // read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_en) begin
      if (rd_hit) begin
        reg_rdata_ff <= regs_ff[rd_idx];
      end else if (reg_addr == chgcfg_pkg::STATUS_OFF) begin
        reg_rdata_ff <= 8'h00;
        reg_rdata_ff[chgcfg_pkg::STAT_FAULT_BIT] <= timer_fault_ff;
        reg_rdata_ff[chgcfg_pkg::STAT_EOC_BIT] <= eoc_detected_ff;
        reg_rdata_ff[chgcfg_pkg::STAT_LBP_BIT] <= boost_lbp_trip_ff;
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  // settings out; a copy keeps the outputs on flops of their own
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_ff <= chgcfg_pkg::chgcfg_cfg_t'({chgcfg_pkg::TERM_RST, chgcfg_pkg::BOOST_RST,
                                           chgcfg_pkg::OPTION_RST, chgcfg_pkg::TIMER_RST});
    end else begin
      cfg_ff.termination_current_level <=
        regs_ff[chgcfg_pkg::TERM_IDX][chgcfg_pkg::TERM_CUR_LSB +: 4];
      cfg_ff.termination_detect_enable <=
        regs_ff[chgcfg_pkg::TERM_IDX][chgcfg_pkg::TERM_EN_BIT];
      cfg_ff.termination_deglitch_select <=
        regs_ff[chgcfg_pkg::TERM_IDX][chgcfg_pkg::TERM_DEG_LSB +: 3];
      // low-battery threshold code; hysteresis lives in the comparator
      cfg_ff.boost_low_battery_threshold <=
        regs_ff[chgcfg_pkg::BOOST_IDX][chgcfg_pkg::BOOST_LBP_LSB +: 4];
      cfg_ff.boost_low_battery_enable <=
        regs_ff[chgcfg_pkg::BOOST_IDX][chgcfg_pkg::BOOST_LBP_EN_BIT];
      cfg_ff.boost_overload_threshold <=
        regs_ff[chgcfg_pkg::BOOST_IDX][chgcfg_pkg::BOOST_OLP_LSB +: 3];
      cfg_ff.adapter_detect_disable <=
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_ADAPTER_DETECT_DISABLE_BIT];
      cfg_ff.battery_presence_detect_enable <=
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_BATTERY_PRESENCE_DETECT_ENABLE_BIT];
      cfg_ff.system_undervoltage_action_select <=
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_UV_SEL_BIT];
      cfg_ff.minimum_system_voltage <=
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_MINIMUM_SYSTEM_VOLTAGE_LSB +: 3];
      cfg_ff.recharge_offset <=
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_RECH_LSB +: 2];
      cfg_ff.fast_charge_time_limit <=
        regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_FC_LSB +: 3];
      cfg_ff.precharge_time_limit <=
        regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_PRC_LSB +: 2];
      cfg_ff.timer_double_enable <=
        regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_DOUBLE_BIT];
      cfg_ff.safety_timer_enable <=
        regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::SAFETY_TIMER_ENABLE_BIT];
      cfg_ff.safety_timer_hold <=
        regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_HOLD_BIT];
    end
  end

  // microsecond and minute enables from one divider chain
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      us_div_ff <= 7'h00;
      min_div_ff <= 26'h0000000;
    end else begin
      us_div_ff <= us_tick ? 7'h00 : us_div_ff + 7'h01;
      if (us_tick) begin
        min_div_ff <= minute_tick ? 26'h0000000 : min_div_ff + 26'h0000001;
      end
    end
  end
  assign us_tick = (us_div_ff == 7'(US_CYCLES - 1));
  assign minute_tick = us_tick && (min_div_ff == 26'(MINUTE_TICKS - 1));

  // termination only watched in fast charge with detection enabled
  assign eoc_cond = sense.term_current_below && sense.phase_fast &&
                    regs_ff[chgcfg_pkg::TERM_IDX][chgcfg_pkg::TERM_EN_BIT];

  // condition must hold for the whole deglitch time, any drop restarts
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      deg_cnt_ff <= 14'h0000;
      eoc_detected_ff <= 1'b0;
    end else if (!eoc_cond) begin
      deg_cnt_ff <= 14'h0000;
      eoc_detected_ff <= 1'b0;
    end else if (deg_cnt_ff >= deglitch_us(
                 regs_ff[chgcfg_pkg::TERM_IDX][chgcfg_pkg::TERM_DEG_LSB +: 3])) begin
      eoc_detected_ff <= 1'b1;
    end else if (us_tick) begin
      deg_cnt_ff <= deg_cnt_ff + 14'h0001;
    end
  end

  // low-battery trip only in boost with protection enabled
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      boost_lbp_trip_ff <= 1'b0;
    end else if (!sense.boost_active ||
                 !regs_ff[chgcfg_pkg::BOOST_IDX][chgcfg_pkg::BOOST_LBP_EN_BIT]) begin
      boost_lbp_trip_ff <= 1'b0;
    end else if (sense.vbat_below_fall) begin
      // trips at falling threshold, releases only above rising one
      boost_lbp_trip_ff <= 1'b1;
    end else if (sense.vbat_above_rise) begin
      boost_lbp_trip_ff <= 1'b0;
    end
  end

  // detection and protection actions
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      buck_switch_off_ff <= 1'b0;
      adapter_detect_run_ff <= 1'b0;
      battery_detect_run_ff <= 1'b0;
      ocp_high_level_ff <= 1'b0;
    end else begin
      buck_switch_off_ff <= sense.system_uv &&
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_UV_SEL_BIT];
      adapter_detect_run_ff <= !regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_ADAPTER_DETECT_DISABLE_BIT];
      battery_detect_run_ff <= sense.charge_done &&
        regs_ff[chgcfg_pkg::OPTION_IDX][chgcfg_pkg::OPT_BATTERY_PRESENCE_DETECT_ENABLE_BIT];
      // inductor overcurrent level, low 6A/5.5A, high 7.5A/7A
      ocp_high_level_ff <= sense.ocp_high_select;
    end
  end

  // phase history; a phase change restarts the count
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= {sense.phase_fast, sense.phase_precharge};
    end
  end

  // timers only with enable and an active charge phase
  assign timer_run = regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::SAFETY_TIMER_ENABLE_BIT] &&
                     (sense.phase_fast || sense.phase_precharge);
  assign timer_restart = (phase_ff != {sense.phase_fast, sense.phase_precharge});
  assign timer_limit = sense.phase_fast ?
    fast_limit_min(regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_FC_LSB +: 3]) :
    pre_limit_min(regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_PRC_LSB +: 2]);

  chgcfg_safety_timer u_safety_timer (
    .clk_sys(clk_sys),
    .rst_sync_b(rst_sync_b),
    .minute_tick(minute_tick),
    .run(timer_run),
    .hold(regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_HOLD_BIT]),
    .half_rate(regs_ff[chgcfg_pkg::TIMER_IDX][chgcfg_pkg::TMR_DOUBLE_BIT] &&
               sense.regulation_active),
    .restart(timer_restart),
    .limit_min(timer_limit),
    .expired(timer_expired)
  );

  // expiry latches the fault; set wins over the clear at phase end
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      timer_fault_ff <= 1'b0;
      charge_stop_ff <= 1'b0;
    end else if (timer_expired) begin
      timer_fault_ff <= 1'b1;
      charge_stop_ff <= 1'b1;
    end else if (!sense.phase_fast && !sense.phase_precharge) begin
      timer_fault_ff <= 1'b0;
      charge_stop_ff <= 1'b0;
    end
  end

endmodule

/* File: verilog/chgcfg_pkg.sv */
package chgcfg_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] TERM_OFF = 8'h09;
  localparam logic [7:0] BOOST_OFF = 8'h0A;
  localparam logic [7:0] OPTION_OFF = 8'h0B;
  localparam logic [7:0] TIMER_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h30;

  // register indices in the storage array
  localparam logic [1:0] TERM_IDX = 2'h0;
  localparam logic [1:0] BOOST_IDX = 2'h1;
  localparam logic [1:0] OPTION_IDX = 2'h2;
  localparam logic [1:0] TIMER_IDX = 2'h3;
  localparam int NUM_REGS = 4;

  // reset values
  localparam logic [7:0] TERM_RST = 8'h3C;
  localparam logic [7:0] BOOST_RST = 8'h58;
  localparam logic [7:0] OPTION_RST = 8'h2C;
  localparam logic [7:0] TIMER_RST = 8'h02;

  // field positions, termination register
  localparam int TERM_CUR_LSB = 4;
  localparam int TERM_EN_BIT = 3;
  localparam int TERM_DEG_LSB = 0;
  // boost protection register
  localparam int BOOST_LBP_LSB = 4;
  localparam int BOOST_LBP_EN_BIT = 3;
  localparam int BOOST_OLP_LSB = 0;
  // option register
  localparam int OPT_ADAPTER_DETECT_DISABLE_BIT = 7;
  localparam int OPT_BATTERY_PRESENCE_DETECT_ENABLE_BIT = 6;
  localparam int OPT_UV_SEL_BIT = 5;
  localparam int OPT_MINIMUM_SYSTEM_VOLTAGE_LSB = 2;
  localparam int OPT_RECH_LSB = 0;
  // safety timer register
  localparam int TMR_FC_LSB = 5;
  localparam int TMR_PRC_LSB = 3;
  localparam int TMR_DOUBLE_BIT = 2;
  localparam int SAFETY_TIMER_ENABLE_BIT = 1;
  localparam int TMR_HOLD_BIT = 0;
  // status register (read only)
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_EOC_BIT = 1;
  localparam int STAT_LBP_BIT = 2;

  // time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int MINUTE_TICKS = 60000000;

  // end-of-charge deglitch times in microseconds
  localparam logic [13:0] DEG_0_US = 14'd32;
  localparam logic [13:0] DEG_1_US = 14'd64;
  localparam logic [13:0] DEG_2_US = 14'd128;
  localparam logic [13:0] DEG_3_US = 14'd256;
  localparam logic [13:0] DEG_4_US = 14'd2000;
  localparam logic [13:0] DEG_5_US = 14'd4000;
  localparam logic [13:0] DEG_6_US = 14'd8000;
  localparam logic [13:0] DEG_7_US = 14'd16000;

  // safety timer limits in minutes
  localparam logic [10:0] FC_0_MIN = 11'd240;
  localparam logic [10:0] FC_1_MIN = 11'd360;
  localparam logic [10:0] FC_2_MIN = 11'd480;
  localparam logic [10:0] FC_3_MIN = 11'd600;
  localparam logic [10:0] FC_4_MIN = 11'd720;
  localparam logic [10:0] FC_5_MIN = 11'd840;
  localparam logic [10:0] FC_6_MIN = 11'd960;
  localparam logic [10:0] FC_7_MIN = 11'd1200;
  localparam logic [10:0] PRC_0_MIN = 11'd30;
  localparam logic [10:0] PRC_1_MIN = 11'd45;
  localparam logic [10:0] PRC_2_MIN = 11'd60;

  // settings handed to the analog loops
  typedef struct packed {
    logic [3:0] termination_current_level;
    logic termination_detect_enable;
    logic [2:0] termination_deglitch_select;
    logic [3:0] boost_low_battery_threshold;
    logic boost_low_battery_enable;
    logic [2:0] boost_overload_threshold;
    logic adapter_detect_disable;
    logic battery_presence_detect_enable;
    logic system_undervoltage_action_select;
    logic [2:0] minimum_system_voltage;
    logic [1:0] recharge_offset;
    logic [2:0] fast_charge_time_limit;
    logic [1:0] precharge_time_limit;
    logic timer_double_enable;
    logic safety_timer_enable;
    logic safety_timer_hold;
  } chgcfg_cfg_t;

  // analog and state inputs, synchronised as one vector
  typedef struct packed {
    logic term_current_below;
    logic phase_precharge;
    logic phase_fast;
    logic regulation_active;
    logic boost_active;
    logic vbat_below_fall;
    logic vbat_above_rise;
    logic system_uv;
    logic charge_done;
    logic ocp_high_select;
  } chgcfg_sense_t;

  localparam int SENSE_W = $bits(chgcfg_sense_t);

endpackage

/* File: verilog/chgcfg_safety_timer.sv */
`timescale 1ns/1ps
// minute counter for the pre-charge and fast-charge safety timers
module chgcfg_safety_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  // control
  input wire logic minute_tick,
  input wire logic run,
  input wire logic hold,
  input wire logic half_rate,
  input wire logic restart,
  input wire logic [10:0] limit_min,
  // result
  output logic expired
);

  logic [10:0] count_ff;
  logic half_ff;

  // count minutes; held count survives a pause
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count_ff <= 11'h000;
      half_ff <= 1'b0;
    end else if (restart || !run) begin
      count_ff <= 11'h000;
      half_ff <= 1'b0;
    end else if (minute_tick && !hold && count_ff < limit_min) begin
      // half rate doubles the time to the same limit
      half_ff <= half_rate ? ~half_ff : 1'b0;
      if (!half_rate || half_ff) begin
        count_ff <= count_ff + 11'h001;
      end
    end
  end

  assign expired = run && !restart && (count_ff >= limit_min);

endmodule

/* File: tb/chgcfg_props.sv */
`timescale 1ns/1ps
// port-level checks of the settings bank
module chgcfg_props #(
  parameter int US_CYCLES = chgcfg_pkg::TICK_CYCLES,
  parameter int MINUTE_TICKS = chgcfg_pkg::MINUTE_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata_ff,
  // sense and settings
  input wire chgcfg_pkg::chgcfg_sense_t sense_async,
  input wire chgcfg_pkg::chgcfg_cfg_t cfg_ff,
  // flags
  input wire logic eoc_detected_ff,
  input wire logic boost_lbp_trip_ff,
  input wire logic buck_switch_off_ff,
  input wire logic adapter_detect_run_ff,
  input wire logic battery_detect_run_ff,
  input wire logic charge_stop_ff,
  input wire logic timer_fault_ff,
  input wire logic ocp_high_level_ff
);
  logic [2:0] up_ff;
  logic [15:0] low_ff;
  logic [2:0] sel;
  logic ok;
  int need;

  // wait out the reset synchroniser
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  assign ok = (up_ff == 3'h7);

  // length of low-current stretch
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      low_ff <= 16'h0000;
    end else begin
      low_ff <= (sense_async.term_current_below && sense_async.phase_fast) ? low_ff + 16'h0001 : 16'h0000;
    end
  end

  // deglitch length in cycles
  always_comb begin
    sel = cfg_ff.termination_deglitch_select;
    need = (sel[2] ? 2000 << sel[1:0] : 32 << sel[1:0]) * US_CYCLES;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_rd_term;
    ok && reg_rd_en && !reg_wr_en && reg_addr == chgcfg_pkg::TERM_OFF
      |=> reg_rdata_ff == cfg_ff[31:24];
  endproperty
  a_rd_term: assert property (p_rd_term) else $error("read data differs from setting");
  property p_eoc_gate;
    (ok && !cfg_ff.termination_detect_enable) [*4] |-> !eoc_detected_ff;
  endproperty
  a_eoc_gate: assert property (p_eoc_gate) else $error("end of charge while disabled");
  property p_eoc_time;
    ok && $rose(eoc_detected_ff) |-> low_ff >= need && low_ff <= need + US_CYCLES + 12;
  endproperty
  a_eoc_time: assert property (p_eoc_time) else $error("end of charge deglitch length off");
  property p_lbp_gate;
    (ok && !cfg_ff.boost_low_battery_enable) [*4] |-> !boost_lbp_trip_ff;
  endproperty
  a_lbp_gate: assert property (p_lbp_gate) else $error("low battery trip while disabled");
  property p_uv;
    (ok && $stable(sense_async.system_uv) && $stable(cfg_ff.system_undervoltage_action_select)) [*4]
      |-> buck_switch_off_ff == (sense_async.system_uv && cfg_ff.system_undervoltage_action_select);
  endproperty
  a_uv: assert property (p_uv) else $error("buck stop on under-voltage wrong");
  property p_adp;
    (ok && $stable(cfg_ff.adapter_detect_disable)) [*3]
      |-> adapter_detect_run_ff == !cfg_ff.adapter_detect_disable;
  endproperty
  a_adp: assert property (p_adp) else $error("adapter detection state wrong");
  property p_batd;
    (ok && $stable(sense_async.charge_done) && $stable(cfg_ff.battery_presence_detect_enable)) [*4]
      |-> battery_detect_run_ff == (sense_async.charge_done && cfg_ff.battery_presence_detect_enable);
  endproperty
  a_batd: assert property (p_batd) else $error("battery detection state wrong");
  property p_stop;
    ok |-> charge_stop_ff == timer_fault_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("charge stop and timer fault differ");
  property p_ocp;
    (ok && $stable(sense_async.ocp_high_select)) [*4]
      |-> ocp_high_level_ff == sense_async.ocp_high_select;
  endproperty
  a_ocp: assert property (p_ocp) else $error("inductor limit level wrong");

  c_eoc: cover property (ok && $rose(eoc_detected_ff));
  c_fault: cover property (ok && $rose(timer_fault_ff));
  c_lbp: cover property (ok && $rose(boost_lbp_trip_ff));
endmodule

bind chgcfg_top chgcfg_props #(.US_CYCLES(US_CYCLES), .MINUTE_TICKS(MINUTE_TICKS))
  u_chgcfg_props (.*);

/* File: tb/chgcfg_plant.sv */
`timescale 1ns/1ps
// battery, adapter and boost load as the charger pins see them
module chgcfg_plant (
  // clock
  input wire logic clk_sys,
  // commanded conditions, battery in 0.1V units
  input wire chgcfg_pkg::chgcfg_sense_t cmd,
  input wire logic [7:0] vbat_dv,
  input wire logic [3:0] lbp_code,
  // levels at the device
  output chgcfg_pkg::chgcfg_sense_t sense_async
);
  logic [7:0] fall_dv;

  // falling threshold, 2.3V plus 0.1V a step
  assign fall_dv = 8'h17 + {4'h0, lbp_code};

  // comparators change just after the edge, like real slow analog
  // hysteresis window
  always @(posedge clk_sys) begin
    sense_async <= cmd;
    sense_async.vbat_below_fall <= vbat_dv < fall_dv;
    sense_async.vbat_above_rise <= vbat_dv >= fall_dv + 8'h04;
  end
  initial sense_async = '0;
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// charger settings bank bench
module tb_top;
  logic clk_sys, rst_b, reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr, reg_wdata, rdata, vbat;
  chgcfg_pkg::chgcfg_sense_t cmd, sense;
  chgcfg_pkg::chgcfg_cfg_t cfg;
  logic eoc, lbp, buck_off, adp_run, batd_run, stop, fault, inductor_overcurrent_level;
  int err_count, comparisons;
  int deg[5] = '{32, 64, 128, 256, 2000};
  logic [7:0] pat[4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};
  logic [7:0] vb[4] = '{8'h1E, 8'h1B, 8'h1F, 8'h20};
  logic lt[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  chgcfg_top #(.US_CYCLES(4), .MINUTE_TICKS(3)) u_chgcfg_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(rdata), .sense_async(sense),
    .cfg_ff(cfg), .eoc_detected_ff(eoc), .boost_lbp_trip_ff(lbp), .buck_switch_off_ff(buck_off),
    .adapter_detect_run_ff(adp_run), .battery_detect_run_ff(batd_run), .charge_stop_ff(stop),
    .timer_fault_ff(fault), .ocp_high_level_ff(inductor_overcurrent_level));
  chgcfg_plant u_chgcfg_plant (.clk_sys(clk_sys), .cmd(cmd), .vbat_dv(vbat),
    .lbp_code(cfg.boost_low_battery_threshold), .sense_async(sense));

  // verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  // registered read data, checked after the edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 chk(32'(rdata), 32'(exp));
  endtask

  function automatic logic flag(input int s);
    return (s == 0) ? eoc : fault;
  endfunction

  // early or missing flag is a miss
  task automatic wait_flag(input int s, input int lo, input int hi);
    int n;
    n = 0;
    while (flag(s) !== 1'b1 && n <= hi) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    if (n > hi) stop_test();
  endtask

  task automatic quiet(input int s, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      chk(32'(flag(s)), 32'h0);
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    vbat = 8'h24;
    cmd = '0;
    err_count = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(chgcfg_pkg::TERM_OFF, 8'h3C);
    rd(chgcfg_pkg::BOOST_OFF, 8'h58);
    rd(chgcfg_pkg::OPTION_OFF, 8'h2C);
    rd(chgcfg_pkg::TIMER_OFF, 8'h02);
    chk(cfg, 32'h3C582C02);
    for (int i = 0; i < 4; i++) begin
      wr(8'h09 + i[7:0], pat[i]);
      rd(8'h09 + i[7:0], pat[i]);
    end
    chk(cfg, 32'hA55AC33C);
    // unmapped and read-only take no write
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(chgcfg_pkg::STATUS_OFF, 8'hFF);
    rd(chgcfg_pkg::STATUS_OFF, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(chgcfg_pkg::OPTION_OFF, {k[0], k[1], k[2], 5'h0C});
      cmd.system_uv <= k[0];
      cmd.charge_done <= !k[0];
      repeat (6) @(negedge clk_sys);
      chk(32'({buck_off, adp_run, batd_run}), 32'({k[0] & k[2], !k[0], !k[0] & k[1]}));
    end
    cmd.boost_active <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(chgcfg_pkg::BOOST_OFF, 8'h58 | c[7:0]);
      // high inductor level for the two top loads
      cmd.ocp_high_select <= (c == 5 || c == 6);
      rd(chgcfg_pkg::BOOST_OFF, 8'h58 | c[7:0]);
      repeat (5) @(negedge clk_sys);
      chk(32'(inductor_overcurrent_level), 32'(c == 5 || c == 6));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      vbat <= vb[i];
      repeat (6) @(negedge clk_sys);
      chk(32'(lbp), 32'(lt[i]));
    end
    wr(chgcfg_pkg::BOOST_OFF, 8'h50);
    vbat <= 8'h1B;
    repeat (6) @(negedge clk_sys);
    chk(32'(lbp), 32'h0);
    // timers off during deglitch runs
    wr(chgcfg_pkg::TIMER_OFF, 8'h00);
    cmd.boost_active <= 1'b0;
    cmd.phase_fast <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      wr(chgcfg_pkg::TERM_OFF, 8'h38 | s[7:0]);
      cmd.term_current_below <= 1'b1;
      wait_flag(0, deg[s] * 4, deg[s] * 4 + 16);
      @(posedge clk_sys);
      cmd.term_current_below <= 1'b0;
      repeat (6) @(negedge clk_sys);
      chk(32'(eoc), 32'h0);
    end
    wr(chgcfg_pkg::TERM_OFF, 8'h30);
    cmd.term_current_below <= 1'b1;
    quiet(0, 300);
    wr(chgcfg_pkg::TIMER_OFF, 8'h03);
    cmd.phase_fast <= 1'b0;
    cmd.phase_precharge <= 1'b1;
    quiet(1, 500);
    wr(chgcfg_pkg::TIMER_OFF, 8'h02);
    wait_flag(1, 340, 400);
    chk(32'(stop), 32'h1);
    cmd.phase_precharge <= 1'b0;
    repeat (6) @(negedge clk_sys);
    chk(32'(fault), 32'h0);
    wr(chgcfg_pkg::TIMER_OFF, 8'h06);
    cmd.regulation_active <= 1'b1;
    cmd.phase_precharge <= 1'b1;
    wait_flag(1, 700, 780);
    wr(chgcfg_pkg::TIMER_OFF, 8'h00);
    cmd.phase_precharge <= 1'b0;
    cmd.regulation_active <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cmd.phase_precharge <= 1'b1;
    quiet(1, 500);
    wr(chgcfg_pkg::TIMER_OFF, 8'h02);
    cmd.phase_precharge <= 1'b0;
    cmd.phase_fast <= 1'b1;
    wait_flag(1, 2850, 2960);
    stop_test();
  end
endmodule
